// [core/psfs_params.svh]
// Offsets, field positions, codes and reset values of the fault status bank
`ifndef PSFS_PARAMS_SVH
`define PSFS_PARAMS_SVH

// Register command codes
`define PSFS_ADDR_SUMMARY      16'h0070
`define PSFS_ADDR_INPUT        16'h0071
`define PSFS_ADDR_OUT_VOLTAGE  16'h0072
`define PSFS_ADDR_OUT_CURRENT  16'h0073

// Function codes
`define PSFS_FN_READ_HOLDING   8'h03
`define PSFS_FN_READ_INPUT     8'h04
`define PSFS_FN_WRITE_SINGLE   8'h06

// Exception codes
`define PSFS_EXC_ILLEGAL_FUNC  8'h01
`define PSFS_EXC_ILLEGAL_ADDR  8'h02

// Summary word bit positions
`define PSFS_SUM_OUT_VOLTAGE   15
`define PSFS_SUM_OUT_CURRENT   14
`define PSFS_SUM_INPUT         13
`define PSFS_SUM_VENDOR        12
`define PSFS_SUM_STANDBY       11
`define PSFS_SUM_FANS          10
`define PSFS_SUM_TEMPERATURE   2

// Input status bit positions
`define PSFS_IN_LINE_FREQ_BAD  15
`define PSFS_IN_PHASE_ORDER    14
`define PSFS_IN_OVERVOLT       7
`define PSFS_IN_UNDERVOLT      4
`define PSFS_IN_OVERCURRENT    2
`define PSFS_IN_POWER_DERATE   1

// Output voltage status bit positions
`define PSFS_OV_SHORT          15
`define PSFS_OV_OVERVOLT       7
`define PSFS_OV_UNDERVOLT      4
`define PSFS_OV_STARTUP_TMO    2

// Output current status bit positions
`define PSFS_OC_OVERCURRENT    7
`define PSFS_OC_OVERPOWER_CC   6

// Reset values
`define PSFS_WORD_RESET        16'h0000
`define PSFS_BYTE_RESET        8'h00

`endif

// [core/psfs_pkg.sv]
// Types shared by the fault status bank
package psfs_pkg;
   typedef logic [15:0] psfs_word_t;   // One status register
   typedef logic [7:0]  psfs_byte_t;   // Function or exception code
   // Kind of answer given to a request
   typedef enum logic [1:0] {
      PSFS_ANS_READ,
      PSFS_ANS_WRITE_ECHO,
      PSFS_ANS_EXCEPTION
   } psfs_answer_t;
endpackage

// [core/psfs_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous levels
module psfs_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;   // First stage, read only by second stage

   // Two stages, constant reset values
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1  <= '0;
         syncOut <= '0;
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// [core/psfs_fault_status.sv]
// Fault status register bank answering decoded serial register requests
//
// Behaviour
// - Read functions 03h and 04h return registers
// - Single-register write function refused with exception 02h
// - Summary bits OR their category registers
// - Line frequency and phase order input flags
// - Input overvoltage flag follows the condition
// - Input undervoltage flag follows the condition
// - Input overcurrent flag follows the condition
// - Input power derating flag follows derating
// - Output short circuit sets latched flag
// - Output overvoltage and output faults stay latched
// - Output undervoltage latched only in voltage mode
// - Startup timeout latched until power cycle
// - Output overcurrent latched until power cycle
// - Overpower in current mode latched
`include "psfs_params.svh"

module psfs_fault_status (
   // Clock and reset (reset is the power cycle)
   input  wire logic                clk,
   input  wire logic                rstn,
   // Fault detector levels, asynchronous
   input  wire logic                lineFreqBad,
   input  wire logic                phaseOrderBad,
   input  wire logic                inOvervolt,
   input  wire logic                inUndervolt,
   input  wire logic                inOvercurrent,
   input  wire logic                inPowerDerate,
   input  wire logic                outShort,
   input  wire logic                outOvervolt,
   input  wire logic                outUndervolt,
   input  wire logic                startupTimeout,
   input  wire logic                outOvercurrent,
   input  wire logic                outOverpowerCc,
   // Operating mode, same clock
   input  wire logic                voltageSourceMode,
   input  wire logic                currentSourceMode,
   // Other category registers, same clock
   input  wire psfs_pkg::psfs_word_t vendorFaultStatus,
   input  wire psfs_pkg::psfs_word_t standbyFaultStatus,
   input  wire psfs_pkg::psfs_word_t fanFaultStatus,
   input  wire psfs_pkg::psfs_word_t temperatureFaultStatus,
   // Decoded request from the framing layer
   input  wire logic                reqValid,
   input  wire psfs_pkg::psfs_byte_t reqFunction,
   input  wire psfs_pkg::psfs_word_t reqAddress,
   input  wire psfs_pkg::psfs_word_t reqData,
   // Answer to the framing layer
   output logic                     respValid,
   output psfs_pkg::psfs_answer_t   respKind,
   output psfs_pkg::psfs_byte_t     respCode,
   output psfs_pkg::psfs_word_t     respAddress,
   output psfs_pkg::psfs_word_t     respData,
   // Register contents for local use
   output psfs_pkg::psfs_word_t     faultSummaryWord
);

   // Synchronised detector levels
   logic [11:0] rawFaults;           // Pin levels, packed
   logic [11:0] syncFaults;          // After two flip-flops
   logic        sLineFreqBad;        // Synchronised line frequency fault
   logic        sPhaseOrderBad;      // Synchronised phase order fault
   logic        sInOvervolt;         // Synchronised input overvoltage
   logic        sInUndervolt;        // Synchronised input undervoltage
   logic        sInOvercurrent;      // Synchronised input overcurrent
   logic        sInPowerDerate;      // Synchronised derating
   logic        sOutShort;           // Synchronised output short
   logic        sOutOvervolt;        // Synchronised output overvoltage
   logic        sOutUndervolt;       // Synchronised output undervoltage
   logic        sStartupTimeout;     // Synchronised startup timeout
   logic        sOutOvercurrent;     // Synchronised output overcurrent
   logic        sOutOverpowerCc;     // Synchronised overpower

   // Latched output faults, cleared only by power cycle
   logic        outShortLatch;       // Output short circuit
   logic        outOvervoltLatch;    // Output overvoltage
   logic        outUndervoltLatch;   // Output undervoltage, voltage mode
   logic        startupTimeoutLatch; // Output never reached target
   logic        outOvercurrentLatch; // Output overcurrent
   logic        outOverpowerLatch;   // Overpower, current mode

   // Assembled register contents
   psfs_pkg::psfs_word_t inputFaultStatus;          // Input category
   psfs_pkg::psfs_word_t outputVoltageFaultStatus;  // Output voltage category
   psfs_pkg::psfs_word_t outputCurrentFaultStatus;  // Output current category
   psfs_pkg::psfs_word_t summaryWord;               // Summary of categories

   // Request decode
   logic        isRead;              // Read holding or read input
   logic        isWrite;             // Write single register
   logic        addrHit;             // Address names a register here
   psfs_pkg::psfs_word_t readMux;    // Selected register
   logic        hitSummary;          // Summary word addressed
   logic        hitInput;            // Input category addressed
   logic        hitOutVolt;          // Output voltage category addressed
   logic        hitOutCurr;          // Output current category addressed

   // Next answer values
   psfs_pkg::psfs_answer_t next_respKind;
   psfs_pkg::psfs_byte_t   next_respCode;
   psfs_pkg::psfs_word_t   next_respData;

   // OR of a whole category register
   function automatic logic anySet(input psfs_pkg::psfs_word_t w);
      // Any set bit raises the summary bit
      return |w;
   endfunction

   // Place one flag at a bit position of an otherwise clear word
   function automatic psfs_pkg::psfs_word_t bitAt(input logic v, input int pos);
      psfs_pkg::psfs_word_t w;
      w = `PSFS_WORD_RESET;
      // Only the low four bits of the position matter
      w[pos[3:0]] = v;
      return w;
   endfunction

   // Pack the pins for the synchroniser
   // Bit order must match the unpack below
   assign rawFaults = {lineFreqBad, phaseOrderBad, inOvervolt, inUndervolt,
                       inOvercurrent, inPowerDerate, outShort, outOvervolt,
                       outUndervolt, startupTimeout, outOvercurrent, outOverpowerCc};

   // Two flip-flops on every detector pin
   // A fault shorter than one clock may go unseen
   psfs_sync #(
      .WIDTH (12)
   ) u_sync (
      .clk     (clk),
      .rstn    (rstn),
      .asyncIn (rawFaults),
      .syncOut (syncFaults)
   );

   // Unpack synchronised levels
   // Input category levels
   assign sLineFreqBad    = syncFaults[11];
   assign sPhaseOrderBad  = syncFaults[10];
   assign sInOvervolt     = syncFaults[9];
   assign sInUndervolt    = syncFaults[8];
   assign sInOvercurrent  = syncFaults[7];
   assign sInPowerDerate  = syncFaults[6];
   // Output category levels
   assign sOutShort       = syncFaults[5];
   assign sOutOvervolt    = syncFaults[4];
   assign sOutUndervolt   = syncFaults[3];
   assign sStartupTimeout = syncFaults[2];
   assign sOutOvercurrent = syncFaults[1];
   assign sOutOverpowerCc = syncFaults[0];

   // Sticky output voltage faults; only power cycle clears them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Power cycle clears every latch
         outShortLatch       <= 1'b0;
         outOvervoltLatch    <= 1'b0;
         outUndervoltLatch   <= 1'b0;
         startupTimeoutLatch <= 1'b0;
      end else begin
         // Set only; nothing clears while powered
         outShortLatch       <= outShortLatch | sOutShort;
         outOvervoltLatch    <= outOvervoltLatch | sOutOvervolt;
         // Undervolt counts only in voltage-source mode
         outUndervoltLatch   <= outUndervoltLatch
                                | (sOutUndervolt & voltageSourceMode);
         startupTimeoutLatch <= startupTimeoutLatch | sStartupTimeout;
      end
   end

   // Sticky output current faults; only power cycle clears them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Power cycle clears every latch
         outOvercurrentLatch <= 1'b0;
         outOverpowerLatch   <= 1'b0;
      end else begin
         // Set only; nothing clears while powered
         outOvercurrentLatch <= outOvercurrentLatch | sOutOvercurrent;
         // Overpower counts only in current-source mode
         outOverpowerLatch   <= outOverpowerLatch
                                | (sOutOverpowerCc & currentSourceMode);
      end
   end

   // Input category: live levels, recover on their own; other bits zero
   assign inputFaultStatus =
        bitAt(sLineFreqBad,   `PSFS_IN_LINE_FREQ_BAD)
      | bitAt(sPhaseOrderBad, `PSFS_IN_PHASE_ORDER)
      | bitAt(sInOvervolt,    `PSFS_IN_OVERVOLT)
      | bitAt(sInUndervolt,   `PSFS_IN_UNDERVOLT)
      | bitAt(sInOvercurrent, `PSFS_IN_OVERCURRENT)
      | bitAt(sInPowerDerate, `PSFS_IN_POWER_DERATE);

   // Output voltage category from latches; other bits zero
   assign outputVoltageFaultStatus =
        bitAt(outShortLatch,       `PSFS_OV_SHORT)
      | bitAt(outOvervoltLatch,    `PSFS_OV_OVERVOLT)
      | bitAt(outUndervoltLatch,   `PSFS_OV_UNDERVOLT)
      | bitAt(startupTimeoutLatch, `PSFS_OV_STARTUP_TMO);

   // Output current category from latches; other bits zero
   assign outputCurrentFaultStatus =
        bitAt(outOvercurrentLatch, `PSFS_OC_OVERCURRENT)
      | bitAt(outOverpowerLatch,   `PSFS_OC_OVERPOWER_CC);

   // Summary: each defined bit ORs one category, others zero
   assign summaryWord =
        bitAt(anySet(outputVoltageFaultStatus), `PSFS_SUM_OUT_VOLTAGE)
      | bitAt(anySet(outputCurrentFaultStatus), `PSFS_SUM_OUT_CURRENT)
      | bitAt(anySet(inputFaultStatus),         `PSFS_SUM_INPUT)
      | bitAt(anySet(vendorFaultStatus),        `PSFS_SUM_VENDOR)
      | bitAt(anySet(standbyFaultStatus),       `PSFS_SUM_STANDBY)
      | bitAt(anySet(fanFaultStatus),           `PSFS_SUM_FANS)
      | bitAt(anySet(temperatureFaultStatus),   `PSFS_SUM_TEMPERATURE);

   // Summary output register, so the port comes from flip-flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Power cycle clears the summary
         faultSummaryWord <= `PSFS_WORD_RESET;
      end else begin
         // One clock behind the live summary
         faultSummaryWord <= summaryWord;
      end
   end

   // Function decode
   assign isRead  = (reqFunction == `PSFS_FN_READ_HOLDING)
                  | (reqFunction == `PSFS_FN_READ_INPUT);
   // Writes are decoded only so that they can be refused
   assign isWrite = (reqFunction == `PSFS_FN_WRITE_SINGLE);

   // One select line per register
   assign hitSummary = (reqAddress == `PSFS_ADDR_SUMMARY);
   assign hitInput   = (reqAddress == `PSFS_ADDR_INPUT);
   assign hitOutVolt = (reqAddress == `PSFS_ADDR_OUT_VOLTAGE);
   assign hitOutCurr = (reqAddress == `PSFS_ADDR_OUT_CURRENT);

   // Register select; unmapped addresses miss
   assign addrHit = hitSummary | hitInput | hitOutVolt | hitOutCurr;

   // Unselected registers contribute zero
   assign readMux =
        (hitSummary ? summaryWord              : 16'h0000)
      | (hitInput   ? inputFaultStatus         : 16'h0000)
      | (hitOutVolt ? outputVoltageFaultStatus : 16'h0000)
      | (hitOutCurr ? outputCurrentFaultStatus : 16'h0000);

   // Answer selection; the bank is read-only, nothing is written
   always_comb begin
      // Default: refuse as an unknown function
      next_respKind = psfs_pkg::PSFS_ANS_EXCEPTION;
      next_respCode = `PSFS_EXC_ILLEGAL_FUNC;
      next_respData = `PSFS_WORD_RESET;
      if (isRead && addrHit) begin
         // Both read functions return the register
         next_respKind = psfs_pkg::PSFS_ANS_READ;
         next_respCode = reqFunction;
         next_respData = readMux;
      end else if (isRead || isWrite) begin
         // Valid function, but address unmapped or register read-only
         next_respKind = psfs_pkg::PSFS_ANS_EXCEPTION;
         next_respCode = `PSFS_EXC_ILLEGAL_ADDR;
         next_respData = reqData & 16'h0000;
      end else begin
         // Any other function code
         next_respKind = psfs_pkg::PSFS_ANS_EXCEPTION;
         next_respCode = `PSFS_EXC_ILLEGAL_FUNC;
      end
   end

   // Answer strobe, one cycle after each request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // No answer pending after power cycle
         respValid <= 1'b0;
      end else begin
         // Every request is taken and answered
         respValid <= reqValid;
      end
   end

   // Answer fields, loaded with each request and held until the next
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         // Neutral answer fields after power cycle
         respKind    <= psfs_pkg::PSFS_ANS_READ;
         respCode    <= `PSFS_BYTE_RESET;
         respAddress <= `PSFS_WORD_RESET;
         respData    <= `PSFS_WORD_RESET;
      end else if (reqValid) begin
         // Capture the answer of the request just taken
         respKind    <= next_respKind;
         respCode    <= next_respCode;
         respAddress <= reqAddress;
         respData    <= next_respData;
      end
   end

endmodule

// [bench/psfs_fault_status_monitor.sv]
// Port checker for the fault status bank, bound to its top module
module psfs_fault_status_monitor (
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rstn,
   // Fault sources
   input wire logic                   inOvervolt,
   input wire psfs_pkg::psfs_word_t   vendorFaultStatus,
   // Request
   input wire logic                   reqValid,
   input wire psfs_pkg::psfs_byte_t   reqFunction,
   input wire psfs_pkg::psfs_word_t   reqAddress,
   // Answer and summary
   input wire logic                   respValid,
   input wire psfs_pkg::psfs_answer_t respKind,
   input wire psfs_pkg::psfs_byte_t   respCode,
   input wire psfs_pkg::psfs_word_t   respData,
   input wire psfs_pkg::psfs_word_t   faultSummaryWord
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // Request classes and answer kinds
   wire logic isRead = reqValid && (reqFunction == 8'h03 || reqFunction == 8'h04);
   wire logic inMap  = reqAddress >= 16'h0070 && reqAddress <= 16'h0073;
   wire logic isExc  = respKind == psfs_pkg::PSFS_ANS_EXCEPTION;
   wire logic isRd   = respKind == psfs_pkg::PSFS_ANS_READ;
   AST_ANSWER: assert property (reqValid |=> respValid)
      else $error("answer missing after request");
   AST_NO_EXTRA: assert property (!reqValid |=> !respValid)
      else $error("answer without request");
   AST_READ: assert property (isRead && inMap |=> isRd && respCode == $past(reqFunction))
      else $error("read not answered with its function code");
   AST_UNMAPPED: assert property (isRead && !inMap |=> isExc && respCode == 8'h02)
      else $error("unmapped read not refused");
   AST_WRITE: assert property (reqValid && reqFunction == 8'h06 |=>
      isExc && respCode == 8'h02 && respData == 16'h0000) else $error("write not refused");
   AST_BAD_FN: assert property (reqValid && !isRead && reqFunction != 8'h06 |=>
      isExc && respCode == 8'h01) else $error("unknown function not refused");
   AST_HOLD: assert property (!reqValid |=> $stable(respData) && $stable(respCode))
      else $error("answer changed without request");
   AST_RESERVED: assert property (faultSummaryWord[9:3] == 7'h00 &&
      faultSummaryWord[1:0] == 2'h0) else $error("reserved summary bit set");
   AST_VENDOR: assert property ((vendorFaultStatus != 16'h0000) [*3] |->
      faultSummaryWord[12]) else $error("vendor summary bit missing");
   AST_INPUT: assert property (inOvervolt [*4] |-> faultSummaryWord[13])
      else $error("input summary bit missing");
   AST_VOUT_STICKY: assert property (faultSummaryWord[15] |=> faultSummaryWord[15])
      else $error("output voltage fault not latched");
   AST_IOUT_STICKY: assert property (faultSummaryWord[14] |=> faultSummaryWord[14])
      else $error("output current fault not latched");
   // Main scenarios reached
   cover property (isRead && reqFunction == 8'h04);
   cover property (reqValid && reqFunction == 8'h06);
   cover property ($rose(faultSummaryWord[15]));
endmodule

bind psfs_fault_status psfs_fault_status_monitor psfs_fault_status_monitor_inst (
   .clk(clk), .rstn(rstn), .inOvervolt(inOvervolt), .vendorFaultStatus(vendorFaultStatus),
   .reqValid(reqValid), .reqFunction(reqFunction), .reqAddress(reqAddress),
   .respValid(respValid), .respKind(respKind), .respCode(respCode), .respData(respData),
   .faultSummaryWord(faultSummaryWord));

// [bench/psfs_host_model.sv]
// Behavioural serial host issuing decoded register requests
module psfs_host_model (
   // Clock
   input  wire logic                   clk,
   // Request
   output logic                        reqValid,
   output psfs_pkg::psfs_byte_t        reqFunction,
   output psfs_pkg::psfs_word_t        reqAddress,
   output psfs_pkg::psfs_word_t        reqData,
   // Answer
   input  wire logic                   respValid,
   input  wire psfs_pkg::psfs_answer_t respKind,
   input  wire psfs_pkg::psfs_byte_t   respCode,
   input  wire psfs_pkg::psfs_word_t   respData
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle before the first request
   initial begin
      reqValid = 1'b0;
      reqFunction = 8'h00;
      reqAddress = 16'h0000;
      reqData = 16'h0000;
   end
   // One request pulse, then a bounded wait for its answer
   task automatic xfer(input logic [7:0] fn, input logic [15:0] ad,
         output psfs_pkg::psfs_answer_t kind, output logic [7:0] code,
         output logic [15:0] rd, output logic ok);
      @(negedge clk);
      reqValid = 1'b1;
      reqFunction = fn;
      reqAddress = ad;
      reqData = 16'h5A5A;
      @(negedge clk);
      // Released lines show the inverse, never the old value
      reqValid = 1'b0;
      reqFunction = ~fn;
      reqAddress = ~ad;
      reqData = 16'hA5A5;
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++) begin
         ok = respValid === 1'b1;
         kind = respKind;
         code = respCode;
         rd = respData;
         if (!ok) @(negedge clk);
      end
   endtask
endmodule

// [bench/psfs_fault_status_test.sv]
// Self-checking bench for the fault status register bank
module psfs_fault_status_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus
   logic                   clk = 1'b0;
   logic                   rstn = 1'b0;
   logic [5:0]             inPins = 6'h00;  // Line freq first, derate last
   logic [5:0]             outPins = 6'h00; // Short first, overpower last
   logic                   voltageMode = 1'b0;
   logic                   currentMode = 1'b0;
   psfs_pkg::psfs_word_t   catWord [4] = '{default: 16'h0000}; // Vendor to temperature
   // Request and answer
   logic                   reqValid, respValid;
   psfs_pkg::psfs_byte_t   reqFunction, respCode;
   psfs_pkg::psfs_word_t   reqAddress, reqData, respAddress, respData, faultSummaryWord;
   psfs_pkg::psfs_answer_t respKind;
   // Bookkeeping and expectation tables
   int                     mismatches = 0;
   int                     comparisons = 0;
   int                     inBit [6] = '{15, 14, 7, 4, 2, 1};
   int                     catBit [4] = '{12, 11, 10, 2};
   logic [15:0]            expVolt [6] = '{16'h8000, 16'h8080, 16'h8090,
                                           16'h8094, 16'h8094, 16'h8094};
   logic [15:0]            expCurr [6] = '{16'h0000, 16'h0000, 16'h0000,
                                           16'h0000, 16'h0080, 16'h00C0};
   // Clock
   always #10 clk = ~clk;
   psfs_fault_status psfs_fault_status_inst (.clk(clk), .rstn(rstn),
      .lineFreqBad(inPins[5]), .phaseOrderBad(inPins[4]), .inOvervolt(inPins[3]),
      .inUndervolt(inPins[2]), .inOvercurrent(inPins[1]), .inPowerDerate(inPins[0]),
      .outShort(outPins[5]), .outOvervolt(outPins[4]), .outUndervolt(outPins[3]),
      .startupTimeout(outPins[2]), .outOvercurrent(outPins[1]), .outOverpowerCc(outPins[0]),
      .voltageSourceMode(voltageMode), .currentSourceMode(currentMode),
      .vendorFaultStatus(catWord[0]), .standbyFaultStatus(catWord[1]),
      .fanFaultStatus(catWord[2]), .temperatureFaultStatus(catWord[3]),
      .reqValid(reqValid), .reqFunction(reqFunction), .reqAddress(reqAddress),
      .reqData(reqData), .respValid(respValid), .respKind(respKind), .respCode(respCode),
      .respAddress(respAddress), .respData(respData), .faultSummaryWord(faultSummaryWord));
   psfs_host_model psfs_host_model_inst (.clk(clk), .reqValid(reqValid),
      .reqFunction(reqFunction), .reqAddress(reqAddress), .reqData(reqData),
      .respValid(respValid), .respKind(respKind), .respCode(respCode), .respData(respData));
   // Counts, verdict and end of run
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One comparison
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One request with its expected answer
   task automatic req(input logic [7:0] fn, input logic [15:0] ad,
         input psfs_pkg::psfs_answer_t eKind, input logic [7:0] eCode, input logic [15:0] eData);
      psfs_pkg::psfs_answer_t kind;
      logic [7:0]  code;
      logic [15:0] data;
      logic        ok;
      psfs_host_model_inst.xfer(fn, ad, kind, code, data, ok);
      chk("answer", 16'h0001, {15'h0000, ok});
      if (ok !== 1'b1) final_report();
      chk("kind", {14'h0000, eKind}, {14'h0000, kind});
      chk("code", {8'h00, eCode}, {8'h00, code});
      chk("address", ad, respAddress);
      chk("data", eData, data);
   endtask
   // Read through both read functions
   task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
      req(8'h03, ad, psfs_pkg::PSFS_ANS_READ, 8'h03, exp);
      req(8'h04, ad, psfs_pkg::PSFS_ANS_READ, 8'h04, exp);
   endtask
   // Main sequence
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      for (int a = 0; a < 4; a++) rd(16'(16'h0070 + a), 16'h0000);
      // Input flags follow their levels
      for (int i = 0; i < 6; i++) begin
         inPins = 6'h20 >> i;
         repeat (3) @(negedge clk);
         rd(16'h0071, 16'h0001 << inBit[i]);
         rd(16'h0070, 16'h2000);
         inPins = 6'h00;
         repeat (3) @(negedge clk);
         rd(16'h0071, 16'h0000);
      end
      // Undervolt and overpower ignored outside their modes
      outPins = 6'h09;
      repeat (3) @(negedge clk);
      outPins = 6'h00;
      rd(16'h0072, 16'h0000);
      rd(16'h0073, 16'h0000);
      // Output faults latch one by one
      voltageMode = 1'b1;
      currentMode = 1'b1;
      for (int i = 0; i < 6; i++) begin
         outPins = 6'h20 >> i;
         repeat (3) @(negedge clk);
         outPins = 6'h00;
         repeat (3) @(negedge clk);
         rd(16'h0072, expVolt[i]);
         rd(16'h0073, expCurr[i]);
      end
      rd(16'h0070, 16'hC000);
      // Other categories feed their summary bits
      for (int i = 0; i < 4; i++) begin
         catWord[i] = 16'h0001 << (3 * i + 1);
         repeat (3) @(negedge clk);
         rd(16'h0070, 16'hC000 | (16'h0001 << catBit[i]));
         chk("summary", 16'hC000 | (16'h0001 << catBit[i]), faultSummaryWord);
         catWord[i] = 16'h0000;
      end
      // Refused writes, unknown function, unmapped addresses
      for (int a = 0; a < 4; a++) begin
         req(8'h06, 16'(16'h0070 + a), psfs_pkg::PSFS_ANS_EXCEPTION, 8'h02, 16'h0000);
      end
      req(8'h10, 16'h0070, psfs_pkg::PSFS_ANS_EXCEPTION, 8'h01, 16'h0000);
      req(8'h03, 16'h0074, psfs_pkg::PSFS_ANS_EXCEPTION, 8'h02, 16'h0000);
      req(8'h04, 16'h006F, psfs_pkg::PSFS_ANS_EXCEPTION, 8'h02, 16'h0000);
      // Power cycle clears latched faults
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      rd(16'h0072, 16'h0000);
      rd(16'h0073, 16'h0000);
      chk("summary", 16'h0000, faultSummaryWord);
      final_report();
   end
endmodule
